// ==== hdl/pwm_dither_top.sv ====
// Dithered 8-bit PWM channel with shared pin and Avalon-MM registers
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps

module pwm_dither_top (
    // Clock, reset, enable
    input  wire logic                                mclk_in,
    input  wire logic                                rst_in,
    input  wire logic                                ce_in,
    // Avalon-MM slave
    input  wire logic [pwm_dither_pkg::ADDR_W-1:0]   address_in,
    input  wire logic                                read_in,
    input  wire logic                                write_in,
    input  wire logic [pwm_dither_pkg::DATA_W-1:0]   writedata_in,
    input  wire logic [pwm_dither_pkg::BE_W-1:0]     byteenable_in,
    output logic      [pwm_dither_pkg::DATA_W-1:0]   readdata_out,
    output logic                                     waitrequest_out,
    // Shared pin
    input  wire logic                                pwm_pin_0_in,
    output logic                                     pwm_pin_0_out,
    output logic                                     pwm_pin_0_oe_n_out,
    output logic                                     pwm_pin_0_pull_high_out
);
    import pwm_dither_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    bus_state_t        bus_state;
    bus_state_t        next_bus_state;
    logic [DUTY_W-1:0] duty_value_reg;
    logic [DUTY_W-1:0] pwm_config_reg_a;
    logic              port_a_output;
    logic              port_a_direction;
    logic              port_a_pullup;
    logic              pin_in_q;
    logic [DUTY_W-1:0] count;
    logic [DUTY_W-1:0] duty_hold;
    logic              mode_hold;
    logic [1:0]        sub_index;
    logic [DUTY_W-1:0] high_time;
    logic              wave;
    logic              req;
    logic              commit_wr;
    logic              lane0;
    logic              hit_duty;
    logic              hit_cfg_a;
    logic              hit_data;
    logic              hit_dir;
    logic              hit_pullup;
    logic              hit_status;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_mux;
    logic              pwm_select;
    logic              mode_select;
    logic              next_pin_out;

    // ---------------------------------------------------------------
    // Waveform engine
    // ---------------------------------------------------------------
    pwm_subcycle_engine #(
        .CNT_W (DUTY_W)
    ) engine (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .ce_in         (ce_in),
        .duty_in       (duty_value_reg),
        .mode_in       (mode_select),
        .count_out     (count),
        .duty_hold_out (duty_hold),
        .mode_hold_out (mode_hold),
        .sub_index_out (sub_index),
        .high_time_out (high_time),
        .wave_out      (wave)
    );

    // ---------------------------------------------------------------
    // Address decode and write strobe
    // ---------------------------------------------------------------
    assign req        = read_in | write_in;
    assign commit_wr  = ce_in & write_in & ~waitrequest_out & (bus_state == BUS_DONE);
    assign lane0      = byteenable_in[0];
    assign hit_duty   = (address_in == OFS_DUTY);
    assign hit_cfg_a  = (address_in == OFS_CFG_A);
    assign hit_data   = (address_in == OFS_PORT_DATA);
    assign hit_dir    = (address_in == OFS_PORT_DIR);
    assign hit_pullup = (address_in == OFS_PULLUP);
    assign hit_status = (address_in == OFS_STATUS);

    // Configuration bits steering the engine and the pin
    assign mode_select = pwm_config_reg_a[CFG_MODE_BIT];
    assign pwm_select  = pwm_config_reg_a[CFG_PSEL_BIT];

    // Status word shows the engine's state and the sampled pin input
    assign status_word = (DATA_W'(count) << ST_COUNT_LSB)
                       | (DATA_W'(duty_hold) << ST_DUTY_LSB)
                       | (DATA_W'(wave) << ST_WAVE_BIT)
                       | (DATA_W'(mode_hold) << ST_MODE_BIT)
                       | (DATA_W'(pin_in_q) << ST_PIN_BIT);

    // Read selection, unmapped addresses read as zero
    assign rd_mux = hit_duty   ? DATA_W'(duty_value_reg)
                  : hit_cfg_a  ? DATA_W'(pwm_config_reg_a)
                  : hit_data   ? (DATA_W'(port_a_output) << PORT_PIN_BIT)
                  : hit_dir    ? (DATA_W'(port_a_direction) << PORT_PIN_BIT)
                  : hit_pullup ? (DATA_W'(port_a_pullup) << PORT_PIN_BIT)
                  : hit_status ? status_word
                  : '0;

    // Next handshake state, one wait cycle per request
    assign next_bus_state = (bus_state == BUS_IDLE && req) ? BUS_DONE : BUS_IDLE;

    // ---------------------------------------------------------------
    // Bus handshake
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_state       <= BUS_IDLE;
            waitrequest_out <= 1'b1;
            readdata_out    <= '0;
        end else if (ce_in) begin
            bus_state       <= next_bus_state;
            waitrequest_out <= (next_bus_state != BUS_DONE);
            if (bus_state == BUS_IDLE && read_in) begin
                readdata_out <= rd_mux;
            end
        end
    end

    // ---------------------------------------------------------------
    // Software registers, written on the accepting edge
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            duty_value_reg   <= DUTY_RST;
            pwm_config_reg_a <= CFG_A_RST;
            port_a_output    <= PORT_DATA_RST;
            port_a_direction <= PORT_DIR_RST;
            port_a_pullup    <= PULLUP_RST;
        end else if (commit_wr && lane0) begin
            if (hit_duty) begin
                duty_value_reg <= writedata_in[DUTY_W-1:0];
            end
            if (hit_cfg_a) begin
                pwm_config_reg_a <= writedata_in[DUTY_W-1:0] & CFG_A_MASK;
            end
            if (hit_data) begin
                port_a_output <= writedata_in[PORT_PIN_BIT];
            end
            if (hit_dir) begin
                port_a_direction <= writedata_in[PORT_PIN_BIT];
            end
            if (hit_pullup) begin
                port_a_pullup <= writedata_in[PORT_PIN_BIT];
            end
        end
    end

    // Pin level: PWM gated by port data, or plain port data
    assign next_pin_out = pwm_select ? (port_a_output & wave)
                                     : port_a_output;

    // ---------------------------------------------------------------
    // Shared pin drivers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pwm_pin_0_out           <= 1'b0;
            pwm_pin_0_oe_n_out      <= 1'b1;
            pwm_pin_0_pull_high_out <= 1'b0;
            pin_in_q                <= 1'b0;
        end else if (ce_in) begin
            pwm_pin_0_out           <= next_pin_out;
            pwm_pin_0_oe_n_out      <= port_a_direction;
            pwm_pin_0_pull_high_out <= port_a_direction & port_a_pullup;
            pin_in_q                <= pwm_pin_0_in;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------

    // Counter steps on each enabled clock
    property p_count_step;
        @(posedge mclk_in) disable iff (rst_in)
        ce_in |=> count == DUTY_W'($past(count) + 1'b1);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("PWM counter did not advance");

    // Counter frozen without enable
    property p_count_hold;
        @(posedge mclk_in) disable iff (rst_in)
        !ce_in |=> count == $past(count);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("PWM counter moved while disabled");

    // Full cycle wraps after 256 clocks
    property p_cycle_wrap;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && count == CNT_LAST) |=> count == CNT_FIRST;
    endproperty
    a_cycle_wrap: assert property (p_cycle_wrap)
        else $error("Full PWM cycle not 256 clocks");

    // Settings are held through a running cycle
    property p_hold_midcycle;
        @(posedge mclk_in) disable iff (rst_in)
        (count != CNT_LAST || !ce_in) |=> duty_hold == $past(duty_hold) && mode_hold == $past(mode_hold);
    endproperty
    a_hold_midcycle: assert property (p_hold_midcycle)
        else $error("Duty changed inside a running cycle");

    // Duty and mode taken at the boundary
    property p_take_at_wrap;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && count == CNT_LAST)
            |=> duty_hold == $past(duty_value_reg) && mode_hold == $past(mode_select);
    endproperty
    a_take_at_wrap: assert property (p_take_at_wrap)
        else $error("New duty or mode not taken at cycle start");

    // Sub-cycle index in 6+2 mode follows the 64-clock blocks
    property p_sub62;
        @(posedge mclk_in) disable iff (rst_in)
        !mode_hold |-> sub_index == count[7:6];
    endproperty
    a_sub62: assert property (p_sub62)
        else $error("6+2 sub-cycle index wrong");

    // Sub-cycle index in 7+1 mode follows the 128-clock halves
    property p_sub71;
        @(posedge mclk_in) disable iff (rst_in)
        mode_hold |-> sub_index == {1'b0, count[7]};
    endproperty
    a_sub71: assert property (p_sub71)
        else $error("7+1 sub-cycle index wrong");

    // 6+2 high time from coarse and fine fields
    property p_high62;
        @(posedge mclk_in) disable iff (rst_in)
        !mode_hold |-> high_time == DUTY_W'(duty_hold[7:2])
                       + DUTY_W'(count[7:6] < duty_hold[1:0]);
    endproperty
    a_high62: assert property (p_high62)
        else $error("6+2 high time wrong");

    // 7+1 high time from coarse and fine fields
    property p_high71;
        @(posedge mclk_in) disable iff (rst_in)
        mode_hold |-> high_time == DUTY_W'(duty_hold[7:1])
                      + DUTY_W'(count[7] < duty_hold[0]);
    endproperty
    a_high71: assert property (p_high71)
        else $error("7+1 high time wrong");

    // 6+2 wave high exactly below the high time
    property p_wave62;
        @(posedge mclk_in) disable iff (rst_in)
        !mode_hold |-> wave == ({2'b00, count[5:0]} < high_time);
    endproperty
    a_wave62: assert property (p_wave62)
        else $error("6+2 waveform wrong");

    // 7+1 wave high exactly below the high time
    property p_wave71;
        @(posedge mclk_in) disable iff (rst_in)
        mode_hold |-> wave == ({1'b0, count[6:0]} < high_time);
    endproperty
    a_wave71: assert property (p_wave71)
        else $error("7+1 waveform wrong");

    // Zero duty keeps the wave low
    property p_zero_low;
        @(posedge mclk_in) disable iff (rst_in)
        duty_hold == DUTY_RST |-> !wave;
    endproperty
    a_zero_low: assert property (p_zero_low)
        else $error("Wave high with zero duty");

    // Enabled PWM passes the wave one clock later
    property p_pin_pwm;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && pwm_select && port_a_output) |=> pwm_pin_0_out == $past(wave);
    endproperty
    a_pin_pwm: assert property (p_pin_pwm)
        else $error("PWM wave not on pin");

    // Port data zero forces the pin low
    property p_pin_off;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && pwm_select && !port_a_output) |=> !pwm_pin_0_out;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("Disabled PWM pin not low");

    // Plain I/O when PWM not selected
    property p_pin_io;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && !pwm_select) |=> pwm_pin_0_out == $past(port_a_output);
    endproperty
    a_pin_io: assert property (p_pin_io)
        else $error("Plain I/O level wrong");

    // Input direction releases the pin and offers the pull-high
    property p_pin_input;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && port_a_direction)
            |=> pwm_pin_0_oe_n_out && pwm_pin_0_pull_high_out == $past(port_a_pullup);
    endproperty
    a_pin_input: assert property (p_pin_input)
        else $error("Input pin still driven");

    // Output direction drives the pin with the pull-high off
    property p_pin_drive;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && !port_a_direction) |=> !pwm_pin_0_oe_n_out && !pwm_pin_0_pull_high_out;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("Output pin not driven");

    // Disabled clock freezes the handshake, the pin and the settings in use
    property p_freeze;
        @(posedge mclk_in) disable iff (rst_in)
        !ce_in |=> $stable(waitrequest_out) && $stable(pwm_pin_0_out) && $stable(duty_hold);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("State moved while disabled");

    // Accepted write lands in the duty register
    sequence s_duty_write;
        commit_wr && lane0 && hit_duty;
    endsequence
    property p_duty_write;
        @(posedge mclk_in) disable iff (rst_in)
        s_duty_write |=> duty_value_reg == $past(writedata_in[DUTY_W-1:0]);
    endproperty
    a_duty_write: assert property (p_duty_write)
        else $error("Duty write lost");

    // Request answered after exactly one wait cycle
    sequence s_new_req;
        ce_in && req && bus_state == BUS_IDLE;
    endsequence
    property p_bus_answer;
        @(posedge mclk_in) disable iff (rst_in)
        s_new_req |=> !waitrequest_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Bus request not answered");

endmodule

// ==== hdl/pwm_dither_pkg.sv ====
// Constants, register map and field layout of the dithered PWM channel

package pwm_dither_pkg;

    // -------------------------------------------------------------------
    // Bus geometry
    // -------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int DUTY_W = 8;

    // -------------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_DUTY      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CFG_A     = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PORT_DATA = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PORT_DIR  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PULLUP    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;

    // -------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------
    localparam int CFG_MODE_BIT  = 5;                 // 1: 7+1 mode
    localparam int CFG_PSEL_BIT  = 3;                 // 1: pin is PWM
    localparam logic [DUTY_W-1:0] CFG_A_MASK = 8'h28;
    localparam int PORT_PIN_BIT  = 4;                 // Pin bit in port regs
    localparam logic [DUTY_W-1:0] DUTY_RST   = 8'h00;
    localparam logic [DUTY_W-1:0] CFG_A_RST  = 8'h00;
    localparam logic PORT_DATA_RST = 1'b0;
    localparam logic PORT_DIR_RST  = 1'b1;            // Input after reset
    localparam logic PULLUP_RST    = 1'b0;
    localparam int ST_COUNT_LSB  = 0;
    localparam int ST_DUTY_LSB   = 8;
    localparam int ST_WAVE_BIT   = 16;
    localparam int ST_MODE_BIT   = 17;
    localparam int ST_PIN_BIT    = 18;

    // -------------------------------------------------------------------
    // Cycle geometry
    // -------------------------------------------------------------------
    localparam int CYCLE_CLKS    = 256;
    localparam logic [DUTY_W-1:0] CNT_LAST   = 8'hFF;
    localparam logic [DUTY_W-1:0] CNT_FIRST  = 8'h00;
    localparam int C62_LSB       = 2;                 // Coarse field, 6+2
    localparam int C71_LSB       = 1;                 // Coarse field, 7+1
    localparam int SUB62_LSB     = 6;                 // 64-clock sub-cycles
    localparam int SUB71_LSB     = 7;                 // 128-clock sub-cycles
    localparam logic [DUTY_W-1:0] POS62_MASK = 8'h3F;
    localparam logic [DUTY_W-1:0] POS71_MASK = 8'h7F;
    localparam logic [DUTY_W-1:0] FINE62_MASK = 8'h03;
    localparam logic [DUTY_W-1:0] FINE71_MASK = 8'h01;
    localparam int CLK_PERIOD_NS = 100;

    // -------------------------------------------------------------------
    // Bus handshake states
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;

endpackage

// ==== hdl/pwm_subcycle_engine.sv ====
// Free-running 256-clock counter and sub-cycle dither waveform
`timescale 1ns/1ps

module pwm_subcycle_engine #(
    parameter int CNT_W = 8
) (
    // Clock, reset, enable
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    // Settings from software
    input  wire logic [CNT_W-1:0] duty_in,
    input  wire logic             mode_in,
    // Engine state
    output logic      [CNT_W-1:0] count_out,
    output logic      [CNT_W-1:0] duty_hold_out,
    output logic                  mode_hold_out,
    output logic      [1:0]       sub_index_out,
    output logic      [CNT_W-1:0] high_time_out,
    output logic                  wave_out
);
    import pwm_dither_pkg::*;

    logic [CNT_W-1:0] pos;
    logic [CNT_W-1:0] coarse_duty;
    logic [1:0]       fine_extra_count;
    logic             extra;

    // ---------------------------------------------------------------
    // Counter and settings taken at the cycle boundary
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            count_out     <= '0;
            duty_hold_out <= DUTY_RST;
            mode_hold_out <= 1'b0;
        end else if (ce_in) begin
            count_out <= count_out + 1'b1;
            if (count_out == CNT_LAST) begin
                duty_hold_out <= duty_in;
                mode_hold_out <= mode_in;
            end
        end
    end

    // Split counter and duty by mode
    assign sub_index_out    = mode_hold_out ? 2'(count_out >> SUB71_LSB)
                                            : 2'(count_out >> SUB62_LSB);
    assign pos              = mode_hold_out ? (count_out & POS71_MASK)
                                            : (count_out & POS62_MASK);
    assign coarse_duty      = mode_hold_out ? (duty_hold_out >> C71_LSB)
                                            : (duty_hold_out >> C62_LSB);
    assign fine_extra_count = mode_hold_out ? 2'(duty_hold_out & FINE71_MASK)
                                            : 2'(duty_hold_out & FINE62_MASK);

    // High time and waveform, high from sub-cycle start
    assign extra         = (sub_index_out < fine_extra_count);
    assign high_time_out = coarse_duty + CNT_W'(extra);
    assign wave_out      = (pos < high_time_out);

endmodule

// ==== testbench/pwm_load_model.sv ====
// Load on the shared pin: resolves the wire level seen by the channel
`timescale 1ns/1ps

module pwm_load_model (
    // Clock and pin side
    input  wire logic mclk_in,
    input  wire logic pin_out_in,
    input  wire logic oe_n_in,
    input  wire logic pull_high_in,
    input  wire logic drive_en_in,
    input  wire logic drive_level_in,
    // Resolved wire
    output logic      level_out
);
    logic churn = 1'b0;

    // Undriven wire changes every cycle so no stale value survives
    always_ff @(posedge mclk_in) churn <= ~churn;

    // Channel first, then the load, then the pull-high
    assign level_out = !oe_n_in ? pin_out_in : drive_en_in ? drive_level_in :
                       pull_high_in ? 1'b1 : churn;
endmodule

// ==== testbench/pwm_subcycle_dither_8bit_bench.sv ====
// Self-checking bench for the dithered PWM channel
`timescale 1ns/1ps

module pwm_subcycle_dither_8bit_bench;
    import pwm_dither_pkg::*;
    logic              mclk_in = 1'b0;
    logic              rst_in  = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic              rd      = 1'b0;
    logic              wr      = 1'b0;
    logic [DATA_W-1:0] wdata   = '0;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] got;
    logic              wait_req;
    logic              pin_out;
    logic              oe_n;
    logic              pull_hi;
    logic              level;
    logic              drv_en  = 1'b0;
    logic              drv_lvl = 1'b0;
    logic              ce      = 1'b1;
    logic [BE_W-1:0]   be      = 4'hF;
    int                errors  = 0;
    int                n_checks = 0;

    pwm_dither_top uut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce),
        .address_in(address), .read_in(rd), .write_in(wr), .writedata_in(wdata),
        .byteenable_in(be), .readdata_out(rdata), .waitrequest_out(wait_req),
        .pwm_pin_0_in(level), .pwm_pin_0_out(pin_out), .pwm_pin_0_oe_n_out(oe_n),
        .pwm_pin_0_pull_high_out(pull_hi));
    pwm_load_model load (.mclk_in(mclk_in), .pin_out_in(pin_out), .oe_n_in(oe_n),
        .pull_high_in(pull_hi), .drive_en_in(drv_en), .drive_level_in(drv_lvl),
        .level_out(level));

    // Clock generator
    initial forever #50 mclk_in = ~mclk_in;

    task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Avalon request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        wr <= w;
        rd <= !w;
        address <= a;
        wdata <= d;
        do begin
            @(posedge mclk_in);
            n++;
        end while (wait_req !== 1'b0 && n < 20);
        got = rdata;
        if (n >= 20) chk("bus answer", 1, 0);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge mclk_in);
    endtask

    // One full cycle measured from a sub-cycle start
    task automatic run_duty(input logic [7:0] duty, input logic mode);
        int hi[4];
        int sub, coarse, k;
        logic prev;
        sub = mode ? 128 : 64;
        coarse = mode ? duty[7:1] : duty[7:2];
        hi = '{default: 0};
        bus(1'b1, OFS_DUTY, {24'h0, duty});
        bus(1'b1, OFS_CFG_A, 32'h0000_0008 | (32'(mode) << 5));
        repeat (300) @(posedge mclk_in);
        #1;
        prev = 1'b1;
        for (k = 0; k < 600 && !(level === 1'b1 && prev === 1'b0); k++) begin
            prev = level;
            @(posedge mclk_in);
            #1;
        end
        for (k = 0; k < 256; k++) begin
            if (k % sub != 0 && level === 1'b1 && prev !== 1'b1) chk("late rise", k, 0);
            hi[k / sub] += (level === 1'b1);
            prev = level;
            @(posedge mclk_in);
            #1;
        end
        for (k = 0; k < 256 / sub; k++) begin
            chk("sub high", 32'(hi[k] == coarse || hi[k] == coarse + 1), 1);
        end
        chk("cycle high", hi[0] + hi[1] + hi[2] + hi[3], duty);
        @(posedge mclk_in);
    endtask

    task automatic final_report;
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [7:0] duties [6] = '{8'h05, 8'hFF, 8'h00, 8'h64, 8'hFF, 8'h03};
        logic       modes [6]  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        int         k;
        logic [7:0] c1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        chk("oe_n after reset", oe_n, 1);
        chk("pull after reset", pull_hi, 0);
        bus(1'b1, OFS_CFG_A, 32'h0000_00FF);
        bus(1'b0, OFS_CFG_A, 0);
        chk("config read", got, 32'h0000_0028);
        bus(1'b0, 8'h40, 0);
        chk("unmapped read", got, 0);
        // Write without the low byte lane must change nothing
        be <= 4'h0;
        bus(1'b1, OFS_CFG_A, 0);
        be <= 4'hF;
        bus(1'b0, OFS_CFG_A, 0);
        chk("masked write", got, 32'h0000_0028);
        bus(1'b1, OFS_PORT_DIR, 0);
        bus(1'b1, OFS_PORT_DATA, 32'h0000_0010);
        for (k = 0; k < 6; k++) run_duty(duties[k], modes[k]);
        bus(1'b1, OFS_PORT_DATA, 0);
        repeat (3) @(posedge mclk_in);
        #1;
        for (k = 0; k < 256; k++) begin
            chk("gated pin", {oe_n, pin_out}, 0);
            @(posedge mclk_in);
            #1;
        end
        @(posedge mclk_in);
        // Counter only advances on enabled clocks: three between the two captures
        bus(1'b0, OFS_STATUS, 0);
        c1 = got[7:0];
        ce <= 1'b0;
        repeat (20) @(posedge mclk_in);
        ce <= 1'b1;
        bus(1'b0, OFS_STATUS, 0);
        chk("frozen count", got[7:0], 8'(c1 + 8'h03));
        bus(1'b1, OFS_PORT_DIR, 32'h0000_0010);
        bus(1'b1, OFS_PULLUP, 32'h0000_0010);
        // Let the pull-high reach the wire and the input sampler
        repeat (2) @(posedge mclk_in);
        bus(1'b0, OFS_STATUS, 0);
        chk("input pull", {oe_n, pull_hi, got[18]}, 3'h7);
        drv_en <= 1'b1;
        repeat (3) @(posedge mclk_in);
        bus(1'b0, OFS_STATUS, 0);
        chk("input low", got[18], 0);
        final_report();
    end

    // Watchdog against a hung handshake
    initial begin
        #3_000_000;
        errors++;
        final_report();
    end
endmodule
